// ---- logic/dcm_channel.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Width field: 00b 8-bit, 01b 16-bit, 10b/11b 32-bit; resets to 11b.
// - Four-bit field inserts 0..15 wait states before every data phase.
// - Ready enable set: ready input ends data phases; clear: input ignored.
// - Burst style bit: 1 continuous bursts, 0 bursts limited to four phases.
// - Burst style bit, with local burst enable also 1, enables burst terminate, which then overrides ready.
// - Burst transfers only while local burst enable is 1, else single transfers.
// - Scatter/gather fetches address and count from descriptors; else one block.
// - Completion interrupt raised only while done-interrupt enable is 1.
// - With clear-count mode in scatter/gather, interrupt waits until the count is written back zero.
// - Addressing bit 1 holds local address constant; 0 increments after each transfer.
// - Clear-count mode zeroes each descriptor's byte count after its transfer.
module dcm_channel
  import dcm_pkg::*;
#(
  parameter int DATA_W     = DCM_DATA_W,
  parameter int FIFO_DEPTH = DCM_FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Mode register, host bus side
  input  wire logic [7:0]             host_reg_addr,
  input  wire logic                   host_reg_wr,
  input  wire logic                   host_reg_rd,
  input  wire logic [31:0]            host_reg_wdata,
  output logic      [31:0]            host_reg_rdata,
  // Mode register, local bus side
  input  wire logic [8:0]             loc_reg_addr,
  input  wire logic                   loc_reg_wr,
  input  wire logic                   loc_reg_rd,
  input  wire logic [31:0]            loc_reg_wdata,
  output logic      [31:0]            loc_reg_rdata,
  // Block mode start values
  input  wire logic                   start,
  input  wire logic [31:0]            blk_laddr,
  input  wire logic [DCM_COUNT_W-1:0] blk_count,
  output logic                        busy,
  // Descriptor fetch and count write-back
  output logic                        desc_req,
  input  wire logic                   desc_ack,
  input  wire logic [31:0]            desc_laddr,
  input  wire logic [DCM_COUNT_W-1:0] desc_count,
  input  wire logic                   desc_last,
  output logic                        count_clear_req,
  input  wire logic                   count_clear_ack,
  // Data stream to be written out on the local bus
  input  wire logic                   src_valid,
  output logic                        src_ready,
  input  wire logic [DATA_W-1:0]      src_data,
  // Local bus master
  output logic                        lb_addr_strobe,
  output logic      [31:0]            lb_addr,
  output logic      [DATA_W-1:0]      lb_data,
  output logic                        lb_data_valid,
  output logic                        lb_burst_last,
  output logic      [1:0]             lb_width,
  input  wire logic                   transfer_ack_input,
  input  wire logic                   burst_terminate_input,
  // Completion
  output logic                        done_pulse,
  output logic                        dma_irq
);

  generate
    if (DATA_W != 32 || FIFO_DEPTH < 2) begin : g_bad
      $error("dcm_channel: DATA_W must be 32 and FIFO_DEPTH at least 2");
    end
  endgenerate

  logic [31:0]            mode_q;
  logic [31:0]            host_rdata_q;
  logic [31:0]            loc_rdata_q;
  dcm_state_t             state_q;
  dcm_state_t             state_d;
  logic [31:0]            addr_q;
  logic [DCM_COUNT_W-1:0] cnt_q;
  logic                   last_desc_q;
  logic [3:0]             ws_cnt_q;
  logic [1:0]             beat_q;
  logic                   done_q;
  logic                   irq_q;

  logic                   fifo_valid;
  logic [DATA_W-1:0]      fifo_data;

  logic [3:0]             ws;
  logic                   rdy_en;
  logic                   cont_burst;
  logic                   burst_en;
  logic                   sg_mode;
  logic                   done_ie;
  logic                   const_addr;
  logic                   clr_cnt;
  logic                   burst_terminate_input_hit;
  logic                   phase_on;
  logic                   phase_end;
  logic                   last_beat;
  logic                   more_beats;
  logic [DCM_COUNT_W-1:0] step;

  // Bytes moved by one data phase at the selected width
  function automatic logic [DCM_COUNT_W-1:0] dcm_step(input logic [1:0] w);
    case (dcm_width_t'(w))
      DCM_W8:  dcm_step = DCM_COUNT_W'(1);
      DCM_W16: dcm_step = DCM_COUNT_W'(2);
      default: dcm_step = DCM_COUNT_W'(4);
    endcase
  endfunction

  // Where a finished block or descriptor leads
  function automatic dcm_state_t dcm_after_block(input logic sg, input logic clr,
                                                 input logic last);
    if (sg && clr) begin
      dcm_after_block = DCM_CLEAR;
    end else if (sg && !last) begin
      dcm_after_block = DCM_FETCH;
    end else begin
      dcm_after_block = DCM_DONE;
    end
  endfunction

  assign lb_width   = mode_q[DCM_WIDTH_LSB +: 2];
  assign step       = dcm_step(lb_width);
  assign ws         = mode_q[DCM_WS_LSB +: 4];
  assign rdy_en     = mode_q[DCM_RDY_EN_BIT];
  assign cont_burst = mode_q[DCM_CONT_BURST_BIT];
  assign burst_en   = mode_q[DCM_BURST_EN_BIT];
  assign sg_mode    = mode_q[DCM_SG_BIT];
  assign done_ie    = mode_q[DCM_DONE_IE_BIT];
  assign const_addr = mode_q[DCM_CONST_ADDR_BIT];
  assign clr_cnt    = mode_q[DCM_CLR_CNT_BIT];

  // Both bus sides write the same register; host wins a same-cycle clash
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= DCM_MODE_RESET;
    end else if (host_reg_wr && host_reg_addr == DCM_MODE_HOST_OFS) begin
      mode_q <= host_reg_wdata & DCM_MODE_WMASK;
    end else if (loc_reg_wr && loc_reg_addr == DCM_MODE_LOCAL_OFS) begin
      mode_q <= loc_reg_wdata & DCM_MODE_WMASK;
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata_q <= '0;
      loc_rdata_q  <= '0;
    end else begin
      host_rdata_q <= (host_reg_rd && host_reg_addr == DCM_MODE_HOST_OFS) ? mode_q : '0;
      loc_rdata_q  <= (loc_reg_rd && loc_reg_addr == DCM_MODE_LOCAL_OFS) ? mode_q : '0;
    end
  end

  assign host_reg_rdata = host_rdata_q;
  assign loc_reg_rdata  = loc_rdata_q;

  dcm_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (fifo_valid),
    .out_ready (phase_end),
    .out_data  (fifo_data)
  );

  // A data phase only runs with a word at the FIFO head, so an empty FIFO stalls the bus
  assign phase_on   = (state_q == DCM_DATA) && fifo_valid;
  assign burst_terminate_input_hit  = burst_en && cont_burst && burst_terminate_input;
  // Terminate ends the phase even when ready has not come
  assign phase_end  = phase_on && (!rdy_en || transfer_ack_input || burst_terminate_input_hit);
  assign last_beat  = (cnt_q <= step);
  assign more_beats = burst_en && !last_beat && !burst_terminate_input_hit
                      && (cont_burst || beat_q != DCM_BURST4_LAST);

  assign lb_addr_strobe = (state_q == DCM_ADDR) && fifo_valid;
  assign lb_addr        = addr_q;
  assign lb_data        = fifo_data;
  assign lb_data_valid  = phase_on;
  assign lb_burst_last  = phase_on && !more_beats;
  assign busy           = (state_q != DCM_IDLE);
  assign desc_req       = (state_q == DCM_FETCH);
  assign count_clear_req = (state_q == DCM_CLEAR);
  assign done_pulse     = done_q;
  assign dma_irq        = irq_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      DCM_IDLE: begin
        if (start) begin
          if (sg_mode) begin
            state_d = DCM_FETCH;
          end else if (blk_count == '0) begin
            state_d = DCM_DONE;
          end else begin
            state_d = DCM_ADDR;
          end
        end
      end
      DCM_FETCH: begin
        if (desc_ack) begin
          if (desc_count == '0) begin
            state_d = dcm_after_block(1'b1, clr_cnt, desc_last);
          end else begin
            state_d = DCM_ADDR;
          end
        end
      end
      DCM_ADDR: begin
        if (fifo_valid) begin
          state_d = (ws == 4'h0) ? DCM_DATA : DCM_WAIT;
        end
      end
      DCM_WAIT: begin
        if (ws_cnt_q == 4'h1) begin
          state_d = DCM_DATA;
        end
      end
      DCM_DATA: begin
        if (phase_end) begin
          if (last_beat) begin
            state_d = dcm_after_block(sg_mode, clr_cnt, last_desc_q);
          end else if (more_beats) begin
            state_d = (ws == 4'h0) ? DCM_DATA : DCM_WAIT;
          end else begin
            state_d = DCM_ADDR;
          end
        end
      end
      DCM_CLEAR: begin
        // Completion is held back until the zeroed count is written back
        if (count_clear_ack) begin
          state_d = last_desc_q ? DCM_DONE : DCM_FETCH;
        end
      end
      DCM_DONE: begin
        state_d = DCM_IDLE;
      end
      default: begin
        state_d = DCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DCM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Transfer address and remaining byte count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q      <= '0;
      cnt_q       <= '0;
      last_desc_q <= 1'b0;
    end else if (state_q == DCM_IDLE && start && !sg_mode) begin
      addr_q      <= blk_laddr;
      cnt_q       <= blk_count;
      last_desc_q <= 1'b1;
    end else if (state_q == DCM_FETCH && desc_ack) begin
      addr_q      <= desc_laddr;
      cnt_q       <= desc_count;
      last_desc_q <= desc_last;
    end else if (phase_end) begin
      cnt_q <= last_beat ? '0 : cnt_q - step;
      if (!const_addr) begin
        addr_q <= addr_q + {{(32 - DCM_COUNT_W){1'b0}}, step};
      end
    end
  end

  // Wait-state countdown, reloaded before every data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ws_cnt_q <= '0;
    end else if ((state_q == DCM_ADDR && fifo_valid) || phase_end) begin
      ws_cnt_q <= ws;
    end else if (state_q == DCM_WAIT) begin
      ws_cnt_q <= ws_cnt_q - 4'h1;
    end
  end

  // Data phase index within the current burst
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_q <= '0;
    end else if (state_q == DCM_ADDR) begin
      beat_q <= '0;
    end else if (phase_end) begin
      beat_q <= beat_q + 2'h1;
    end
  end

  // Completion strobes: done always, interrupt only when enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      done_q <= (state_q == DCM_DONE);
      irq_q  <= (state_q == DCM_DONE) && done_ie;
    end
  end

endmodule

`default_nettype wire

// ---- logic/dcm_pkg.sv ----
`default_nettype none

package dcm_pkg;

  // Mode register placement, one per bus side
  localparam logic [7:0]  DCM_MODE_HOST_OFS  = 8'h94;
  localparam logic [8:0]  DCM_MODE_LOCAL_OFS = 9'h114;

  // Field positions inside the mode register
  localparam int          DCM_WIDTH_LSB      = 0;
  localparam int          DCM_WS_LSB         = 2;
  localparam int          DCM_RDY_EN_BIT     = 6;
  localparam int          DCM_CONT_BURST_BIT = 7;
  localparam int          DCM_BURST_EN_BIT   = 8;
  localparam int          DCM_SG_BIT         = 9;
  localparam int          DCM_DONE_IE_BIT    = 10;
  localparam int          DCM_CONST_ADDR_BIT = 11;
  localparam int          DCM_CLR_CNT_BIT    = 16;

  // 32-bit width, zero wait states, ready input enabled
  localparam logic [31:0] DCM_MODE_RESET     = 32'h0000_0043;
  // Only the implemented fields store; the rest read as zero
  localparam logic [31:0] DCM_MODE_WMASK     = 32'h0001_0fff;

  localparam int          DCM_COUNT_W        = 23;
  localparam int          DCM_DATA_W         = 32;
  localparam int          DCM_FIFO_DEPTH     = 16;
  // Index of the fourth data phase in a limited burst
  localparam logic [1:0]  DCM_BURST4_LAST    = 2'h3;

  typedef enum logic [1:0] {
    DCM_W8   = 2'b00,
    DCM_W16  = 2'b01,
    DCM_W32A = 2'b10,
    DCM_W32B = 2'b11
  } dcm_width_t;

  typedef enum logic [2:0] {
    DCM_IDLE  = 3'b000,
    DCM_FETCH = 3'b001,
    DCM_ADDR  = 3'b010,
    DCM_WAIT  = 3'b011,
    DCM_DATA  = 3'b100,
    DCM_CLEAR = 3'b101,
    DCM_DONE  = 3'b110
  } dcm_state_t;

endpackage

`default_nettype wire

// ---- logic/dcm_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module dcm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("dcm_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    level_q;
  logic             push;
  logic             pop;

  assign in_ready  = (level_q != CW'(DEPTH));
  assign out_valid = (level_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        level_q <= level_q + CW'(1);
      end else if (pop && !push) begin
        level_q <= level_q - CW'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/dcm_lb_target.sv ----
`timescale 1ns/10ps
`default_nettype none

module dcm_lb_target (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        rdy_en,
  input  wire logic [7:0]  ack_dly,
  input  wire logic [7:0]  term_at,
  input  wire logic        lb_data_valid,
  input  wire logic [31:0] lb_addr,
  input  wire logic [31:0] lb_data,
  output logic             transfer_ack_input,
  output logic             burst_terminate_input,
  output logic [7:0]       wr_n,
  output logic [31:0]      last_addr,
  output logic [31:0]      last_data
);
  logic [7:0] wait_q;
  logic       taken;

  // Strobes are driven inactive between phases, never left floating
  assign transfer_ack_input    = lb_data_valid && (wait_q >= ack_dly);
  // Terminate on the chosen phase of a transfer, counted from one; zero fires on the 256th phase and every 256th after
  assign burst_terminate_input = lb_data_valid && (wr_n + 8'h1 == term_at);
  assign taken = lb_data_valid && (transfer_ack_input || !rdy_en || burst_terminate_input);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q    <= 8'h0;
      wr_n      <= 8'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
    end else if (start) begin
      wait_q <= 8'h0;
      wr_n   <= 8'h0;
    end else if (taken) begin
      wait_q    <= 8'h0;
      wr_n      <= wr_n + 8'h1;
      last_addr <= lb_addr;
      last_data <= lb_data;
    end else if (lb_data_valid) begin
      wait_q <= wait_q + 8'h1;
    end
  end
endmodule

`default_nettype wire

// ---- tb/dcm_channel_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module dcm_channel_sva
  import dcm_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  host_reg_addr,
  input wire logic        host_reg_wr,
  input wire logic        host_reg_rd,
  input wire logic [31:0] host_reg_wdata,
  input wire logic [31:0] host_reg_rdata,
  input wire logic [8:0]  loc_reg_addr,
  input wire logic        loc_reg_wr,
  input wire logic [31:0] loc_reg_wdata,
  input wire logic        count_clear_req,
  input wire logic        lb_addr_strobe,
  input wire logic [31:0] lb_addr,
  input wire logic        lb_data_valid,
  input wire logic        lb_burst_last,
  input wire logic [1:0]  lb_width,
  input wire logic        transfer_ack_input,
  input wire logic        burst_terminate_input,
  input wire logic        done_pulse,
  input wire logic        dma_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [31:0] mode_q;
  logic [31:0] step;
  logic [4:0]  gap_q;
  logic        pend_q;
  logic [2:0]  beats_q;
  logic        term_hit;
  logic        phase_end;

  assign step      = mode_q[1] ? 32'h4 : (mode_q[0] ? 32'h2 : 32'h1);
  assign term_hit  = lb_data_valid && mode_q[8] && mode_q[7] && burst_terminate_input;
  assign phase_end = lb_data_valid && (!mode_q[6] || transfer_ack_input || term_hit);

  // Shadow of the mode register; host wins a same-cycle write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= DCM_MODE_RESET;
    end else if (host_reg_wr && host_reg_addr == DCM_MODE_HOST_OFS) begin
      mode_q <= host_reg_wdata & DCM_MODE_WMASK;
    end else if (loc_reg_wr && loc_reg_addr == DCM_MODE_LOCAL_OFS) begin
      mode_q <= loc_reg_wdata & DCM_MODE_WMASK;
    end
  end

  // Idle cycles since an address phase or a data phase end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q  <= 5'h0;
      pend_q <= 1'b0;
    end else if (lb_addr_strobe || phase_end) begin
      gap_q  <= 5'h0;
      pend_q <= 1'b1;
    end else if (lb_data_valid) begin
      pend_q <= 1'b0;
    end else if (pend_q) begin
      gap_q <= gap_q + 5'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      beats_q <= 3'h0;
    end else if (lb_addr_strobe) begin
      beats_q <= 3'h0;
    end else if (phase_end) begin
      beats_q <= beats_q + 3'h1;
    end
  end

  sequence s_held_phase;
    lb_data_valid && mode_q[6] && !transfer_ack_input && !term_hit;
  endsequence

  mode_read_a: assert property (host_reg_rd && host_reg_addr == DCM_MODE_HOST_OFS
    |=> host_reg_rdata == $past(mode_q)) else $error("mode read value wrong");
  rdata_idle_a: assert property (!(host_reg_rd && host_reg_addr == DCM_MODE_HOST_OFS)
    |=> host_reg_rdata == 32'h0) else $error("read data not zero");
  width_out_a: assert property ($stable(mode_q[1:0]) |-> lb_width == mode_q[1:0])
    else $error("width output wrong");
  wait_gap_a: assert property (lb_data_valid && pend_q |-> gap_q == {1'b0, mode_q[5:2]})
    else $error("wait state count wrong");
  ready_hold_a: assert property (s_held_phase |=> lb_data_valid && $stable(lb_addr))
    else $error("phase ended without ready");
  burst_four_a: assert property (lb_data_valid && mode_q[8] && !mode_q[7] && beats_q == 3'h3
    |-> lb_burst_last) else $error("burst longer than four");
  term_ends_a: assert property (term_hit |=> !lb_data_valid)
    else $error("terminate did not end burst");
  single_xfer_a: assert property (lb_data_valid && !mode_q[8] |-> lb_burst_last)
    else $error("burst while bursting off");
  irq_gate_a: assert property (done_pulse || dma_irq |-> dma_irq == (done_pulse && mode_q[10]))
    else $error("interrupt gating wrong");
  clear_first_a: assert property (count_clear_req |-> !dma_irq && !done_pulse)
    else $error("interrupt before count cleared");
  addr_step_a: assert property (phase_end |=> lb_addr == $past(lb_addr)
    + ($past(mode_q[11]) ? 32'h0 : $past(step))) else $error("address step wrong");
endmodule

bind dcm_channel dcm_channel_sva chk_u (
  .clk(clk), .reset_n(reset_n), .host_reg_addr(host_reg_addr), .host_reg_wr(host_reg_wr),
  .host_reg_rd(host_reg_rd), .host_reg_wdata(host_reg_wdata), .host_reg_rdata(host_reg_rdata),
  .loc_reg_addr(loc_reg_addr), .loc_reg_wr(loc_reg_wr), .loc_reg_wdata(loc_reg_wdata),
  .count_clear_req(count_clear_req), .lb_addr_strobe(lb_addr_strobe), .lb_addr(lb_addr),
  .lb_data_valid(lb_data_valid), .lb_burst_last(lb_burst_last), .lb_width(lb_width),
  .transfer_ack_input(transfer_ack_input), .burst_terminate_input(burst_terminate_input),
  .done_pulse(done_pulse), .dma_irq(dma_irq)
);

`default_nettype wire

// ---- tb/dcm_channel_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module dcm_channel_tb_top
  import dcm_pkg::*;
;
  logic                   clk, reset_n, host_reg_wr, host_reg_rd, loc_reg_wr, loc_reg_rd;
  logic [7:0]             host_reg_addr, ack_dly, term_at, wr_n;
  logic [8:0]             loc_reg_addr;
  logic [31:0]            host_reg_wdata, host_reg_rdata, loc_reg_wdata, loc_reg_rdata;
  logic                   start, busy, desc_req, desc_ack, desc_last, count_clear_req;
  logic [31:0]            blk_laddr, desc_laddr, src_data, lb_addr, lb_data, last_addr, last_data;
  logic [DCM_COUNT_W-1:0] blk_count, desc_count;
  logic                   src_valid, src_ready, lb_addr_strobe, lb_data_valid, lb_burst_last;
  logic [1:0]             lb_width;
  logic                   transfer_ack_input, burst_terminate_input, done_pulse, dma_irq;
  logic                   count_clear_ack, rdy_en;
  int                     fails, cmp_count, wseq, strb_n, irq_n, clr_n, didx, n;

  dcm_channel dut_u (
    .clk(clk), .reset_n(reset_n), .host_reg_addr(host_reg_addr), .host_reg_wr(host_reg_wr),
    .host_reg_rd(host_reg_rd), .host_reg_wdata(host_reg_wdata), .host_reg_rdata(host_reg_rdata),
    .loc_reg_addr(loc_reg_addr), .loc_reg_wr(loc_reg_wr), .loc_reg_rd(loc_reg_rd),
    .loc_reg_wdata(loc_reg_wdata), .loc_reg_rdata(loc_reg_rdata), .start(start),
    .blk_laddr(blk_laddr), .blk_count(blk_count), .busy(busy), .desc_req(desc_req),
    .desc_ack(desc_ack), .desc_laddr(desc_laddr), .desc_count(desc_count),
    .desc_last(desc_last), .count_clear_req(count_clear_req), .count_clear_ack(count_clear_ack),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .lb_addr_strobe(lb_addr_strobe), .lb_addr(lb_addr), .lb_data(lb_data),
    .lb_data_valid(lb_data_valid), .lb_burst_last(lb_burst_last), .lb_width(lb_width),
    .transfer_ack_input(transfer_ack_input), .burst_terminate_input(burst_terminate_input),
    .done_pulse(done_pulse), .dma_irq(dma_irq)
  );

  dcm_lb_target tgt_u (
    .clk(clk), .reset_n(reset_n), .start(start), .rdy_en(rdy_en), .ack_dly(ack_dly),
    .term_at(term_at), .lb_data_valid(lb_data_valid), .lb_addr(lb_addr), .lb_data(lb_data),
    .transfer_ack_input(transfer_ack_input), .burst_terminate_input(burst_terminate_input),
    .wr_n(wr_n), .last_addr(last_addr), .last_data(last_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Descriptor memory answers one cycle after the request; counters only touched on events to avoid races
  always @(posedge clk) begin
    desc_ack <= (desc_req === 1'b1) && (desc_ack !== 1'b1);
    count_clear_ack <= (count_clear_req === 1'b1) && (count_clear_ack !== 1'b1);
    if (desc_req === 1'b1 && desc_ack !== 1'b1) begin
      desc_laddr <= 32'h400 + 32'(didx) * 32'h100;
      desc_count <= 23'h8;
      desc_last <= (didx == 1);
      didx++;
    end
    if (count_clear_req === 1'b1 && count_clear_ack !== 1'b1) clr_n++;
    if (lb_addr_strobe === 1'b1) strb_n++;
    if (dma_irq === 1'b1) irq_n++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input bit loc, input bit wr, input logic [8:0] a, input logic [31:0] d);
    host_reg_wr <= wr && !loc;
    host_reg_rd <= !wr && !loc;
    loc_reg_wr <= wr && loc;
    loc_reg_rd <= !wr && loc;
    host_reg_addr <= a[7:0];
    loc_reg_addr <= a;
    host_reg_wdata <= d;
    loc_reg_wdata <= d;
    @(posedge clk);
    {host_reg_wr, host_reg_rd, loc_reg_wr, loc_reg_rd} <= 4'h0;
    @(posedge clk);
    if (!wr) chk(loc ? loc_reg_rdata : host_reg_rdata, d);
  endtask

  task automatic push(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      src_valid <= 1'b1;
      src_data <= 32'ha500_0000 + 32'(wseq);
      wseq++;
      @(posedge clk);
      while (src_ready !== 1'b1) @(posedge clk);
    end
    src_valid <= 1'b0;
  endtask

  task automatic run(input logic [31:0] mode, input logic [22:0] cnt, input int nw, dly, trm,
                     input int ewr, input logic [31:0] eaddr, input int estb, eirq);
    acc(1'b0, 1'b1, 9'h094, mode);
    rdy_en <= mode[6];
    ack_dly <= 8'(dly);
    term_at <= 8'(trm);
    {strb_n, irq_n, clr_n, didx, n} = '0;
    push(nw);
    start <= 1'b1;
    blk_laddr <= 32'h100;
    blk_count <= cnt;
    @(posedge clk);
    start <= 1'b0;
    while (done_pulse !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      if (n == 1) chk(32'(busy), 32'h1);
    end
    @(posedge clk);
    if (n >= 3000) chk(32'h0, 32'h1);
    chk(32'(busy), 32'h0);
    chk(32'(wr_n), 32'(ewr));
    chk(last_addr, eaddr);
    chk(last_data, 32'ha500_0000 + 32'(wseq - 1));
    chk(32'(strb_n), 32'(estb));
    chk(32'(irq_n), 32'(eirq));
    $display("Test done: mode %h", mode);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    {reset_n, host_reg_wr, host_reg_rd, loc_reg_wr, loc_reg_rd, start, src_valid} = '0;
    {rdy_en, host_reg_addr, loc_reg_addr} = '0;
    {host_reg_wdata, loc_reg_wdata, blk_laddr, blk_count} = '0;
    {src_data, ack_dly, term_at} = '0;
    {fails, cmp_count, wseq, strb_n, irq_n, clr_n, didx, n} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    acc(1'b0, 1'b0, 9'h094, 32'h0000_0043);
    acc(1'b1, 1'b0, 9'h114, 32'h0000_0043);
    acc(1'b0, 1'b0, 9'h090, 32'h0);
    acc(1'b1, 1'b1, 9'h114, 32'hffff_ffff);
    acc(1'b0, 1'b1, 9'h098, 32'h0);
    acc(1'b0, 1'b0, 9'h094, 32'h0001_0fff);
    $display("Test done: registers");
    run(32'h440, 23'h4, 4, 0, 0, 4, 32'h103, 4, 1);
    run(32'h441, 23'h4, 2, 1, 0, 2, 32'h102, 2, 1);
    run(32'h442, 23'h8, 2, 0, 0, 2, 32'h104, 2, 1);
    run(32'h44f, 23'h8, 2, 3, 0, 2, 32'h104, 2, 1);
    run(32'h803, 23'hc, 3, 255, 0, 3, 32'h100, 3, 0);
    run(32'h547, 23'h18, 6, 0, 0, 6, 32'h114, 2, 1);
    run(32'h5c3, 23'h18, 6, 1, 0, 6, 32'h114, 1, 1);
    run(32'h5c3, 23'h18, 6, 0, 2, 6, 32'h114, 2, 1);
    push(16);
    @(posedge clk);
    chk(32'(src_ready), 32'h0);
    run(32'h443, 23'h40, 0, 2, 0, 16, 32'h13c, 16, 1);
    run(32'h643, 23'h0, 4, 0, 0, 4, 32'h504, 4, 1);
    chk(32'(clr_n), 32'h0);
    run(32'h10643, 23'h0, 4, 0, 0, 4, 32'h504, 4, 1);
    chk(32'(clr_n), 32'h2);
    summarize();
  end
endmodule

`default_nettype wire
